//--- rtl/ccau_params.svh
// Purpose: Constants for the capture/compare array unit
// Assumes: Included by bare name
// Notes: Widths, counts, limits and reset values; types live in the package
`ifndef CCAU_PARAMS_SVH
`define CCAU_PARAMS_SVH
`define CCAU_NCH 16
`define CCAU_HALF 8
`define CCAU_TW 16
`define CCAU_PW 3
`define CCAU_DIVW 8
`define CCAU_SLOTW 3
`define CCAU_TB_MAX 16'hFFFF
`define CCAU_VAL_RST 16'h0000
`define CCAU_DIV_RST 8'h00
`define CCAU_SLOT_RST 3'h0
`endif

//--- rtl/ccau_pkg.sv
// Purpose: Types of the capture/compare array unit
// Assumes: ccau_params.svh supplies the widths
// Notes: Modes cover capture edges and the four compare modes
`include "ccau_params.svh"
package ccau_pkg;
  typedef enum logic [1:0] {
    ccau_src_presc,
    ccau_src_neighbour,
    ccau_src_external
  } ccau_src_t;
  typedef enum logic [2:0] {
    ccau_mode_off,
    ccau_cap_rise,
    ccau_cap_fall,
    ccau_cap_both,
    ccau_cmp0,
    ccau_cmp1,
    ccau_cmp2,
    ccau_cmp3
  } ccau_mode_t;
  typedef struct packed {
    logic run;
    ccau_src_t src;
    logic [`CCAU_PW-1:0] presc;
    logic [`CCAU_TW-1:0] reload;
  } ccau_tb_cfg_t;
  typedef struct packed {
    ccau_mode_t mode;
    logic tb_sel;
    logic single_event;
    logic double_reg;
  } ccau_ch_cfg_t;
endpackage

//--- rtl/ccau_timebase.sv
// Purpose: One reloadable 16-bit timebase with clock selection
// Assumes: ext_tick and nb_tick are one-cycle pulses on clk
// Notes: Prescaler divides by two to the power of presc
`timescale 1ns/1ps
module ccau_timebase
  import ccau_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input ccau_tb_cfg_t cfg,
  input wire logic ext_tick,
  input wire logic nb_tick,
  input wire logic load,
  input wire logic [`CCAU_TW-1:0] load_value,
  output logic [`CCAU_TW-1:0] value,
  output logic stepped,
  output logic ovf
);
  logic [`CCAU_DIVW-1:0] div;
  logic [`CCAU_DIVW-1:0] next_div;
  logic [`CCAU_TW-1:0] next_value;
  logic next_stepped;
  logic next_ovf;
  logic tick;

  function automatic logic presc_hit(input logic [`CCAU_DIVW-1:0] d,
                                     input logic [`CCAU_PW-1:0] p);
    logic [`CCAU_DIVW-1:0] mask;
    mask = (`CCAU_DIVW'(1) << p) - `CCAU_DIVW'(1);
    return (d & mask) == mask;
  endfunction

  always_comb begin
    next_div = div + `CCAU_DIVW'(1);
    unique case (cfg.src)
      ccau_src_presc: tick = presc_hit(div, cfg.presc);
      ccau_src_neighbour: tick = nb_tick;
      ccau_src_external: tick = ext_tick;
      default: tick = 1'b0;
    endcase
    next_value = value;
    next_stepped = 1'b0;
    next_ovf = 1'b0;
    if (load) begin
      next_value = load_value;
    end else if (cfg.run && tick) begin
      next_stepped = 1'b1;
      if (value == `CCAU_TB_MAX) begin
        next_value = cfg.reload;
        next_ovf = 1'b1;
      end else begin
        next_value = value + `CCAU_TW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div <= `CCAU_DIV_RST;
      value <= `CCAU_VAL_RST;
      stepped <= 1'b0;
      ovf <= 1'b0;
    end else begin
      div <= next_div;
      value <= next_value;
      stepped <= next_stepped;
      ovf <= next_ovf;
    end
  end
endmodule // ccau_timebase

//--- rtl/ccau_top.sv
// Purpose: Sixteen-channel capture/compare array on two timebases
// Assumes: Pins and the external count input are asynchronous
// Notes: All configuration arrives on plain ports, no bus
`timescale 1ns/1ps
module ccau_top
  import ccau_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic staggered,
  input ccau_tb_cfg_t [1:0] tb_cfg,
  input wire logic [1:0] tb_load,
  input wire logic [1:0][`CCAU_TW-1:0] tb_load_value,
  input wire logic nb_tick,
  input wire logic ext_count_pin,
  input ccau_ch_cfg_t [`CCAU_NCH-1:0] ch_cfg,
  input wire logic [`CCAU_NCH-1:0] cc_wr,
  input wire logic [`CCAU_TW-1:0] cc_wdata,
  input wire logic [`CCAU_NCH-1:0] ch_pin_in,
  output logic [1:0][`CCAU_TW-1:0] tb_value,
  output logic [1:0] tb_ovf,
  output logic [`CCAU_NCH-1:0][`CCAU_TW-1:0] cc_value,
  output logic [`CCAU_NCH-1:0] cc_irq,
  output logic [`CCAU_NCH-1:0] ch_pin_out,
  output logic [`CCAU_NCH-1:0] ch_pin_oe_n
);
  // Pin and external input synchronisers
  logic [`CCAU_NCH-1:0] pin_s1;
  logic [`CCAU_NCH-1:0] pin_s2;
  logic [`CCAU_NCH-1:0] pin_s3;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_tick;

  // Timebase outputs
  logic [1:0] tb_stepped;

  // Channel state
  logic [`CCAU_NCH-1:0][`CCAU_TW-1:0] next_cc_value;
  logic [`CCAU_NCH-1:0] pend;
  logic [`CCAU_NCH-1:0] next_pend;
  logic [`CCAU_NCH-1:0] fired;
  logic [`CCAU_NCH-1:0] next_fired;
  logic [`CCAU_NCH-1:0] spent;
  logic [`CCAU_NCH-1:0] next_spent;
  logic [`CCAU_NCH-1:0] next_cc_irq;
  logic [`CCAU_NCH-1:0] next_ch_pin_out;
  logic [`CCAU_NCH-1:0] next_ch_pin_oe_n;
  logic [`CCAU_SLOTW-1:0] slot;
  logic [`CCAU_SLOTW-1:0] next_slot;

  // Per-channel working terms
  logic [`CCAU_NCH-1:0] edge_hit;
  logic [`CCAU_NCH-1:0] raw_evt;
  logic [`CCAU_NCH-1:0] slot_ok;
  logic [`CCAU_NCH-1:0] hit;
  logic [`CCAU_NCH-1:0] match;
  logic [`CCAU_NCH-1:0] own_ovf;
  logic [`CCAU_NCH-1:0] toggle;

  function automatic logic is_cap(input ccau_mode_t m);
    return (m == ccau_cap_rise) || (m == ccau_cap_fall) || (m == ccau_cap_both);
  endfunction

  function automatic logic is_cmp(input ccau_mode_t m);
    return (m == ccau_cmp0) || (m == ccau_cmp1) || (m == ccau_cmp2) || (m == ccau_cmp3);
  endfunction

  function automatic logic is_once(input ccau_mode_t m);
    return (m == ccau_cmp2) || (m == ccau_cmp3);
  endfunction

  function automatic logic drives_pin(input ccau_mode_t m);
    return (m == ccau_cmp1) || (m == ccau_cmp3);
  endfunction

  // Input synchronisers; only the second stage onward is looked at
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      pin_s1 <= ch_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Rising edge of the external count input
  assign ext_tick = ext_s2 & ~ext_s3;

  ccau_timebase u_timebase_first (
    .clk(clk),
    .reset(reset),
    .cfg(tb_cfg[0]),
    .ext_tick(ext_tick),
    .nb_tick(nb_tick),
    .load(tb_load[0]),
    .load_value(tb_load_value[0]),
    .value(tb_value[0]),
    .stepped(tb_stepped[0]),
    .ovf(tb_ovf[0])
  );

  // Second timebase has no external count input
  ccau_timebase u_timebase_second (
    .clk(clk),
    .reset(reset),
    .cfg(tb_cfg[1]),
    .ext_tick(1'b0),
    .nb_tick(nb_tick),
    .load(tb_load[1]),
    .load_value(tb_load_value[1]),
    .value(tb_value[1]),
    .stepped(tb_stepped[1]),
    .ovf(tb_ovf[1])
  );

  // Event detection and compare evaluation
  always_comb begin
    next_slot = slot + `CCAU_SLOTW'(1);
    for (int i = 0; i < `CCAU_NCH; i++) begin
      unique case (ch_cfg[i].mode)
        ccau_cap_rise: edge_hit[i] = pin_s2[i] & ~pin_s3[i];
        ccau_cap_fall: edge_hit[i] = ~pin_s2[i] & pin_s3[i];
        ccau_cap_both: edge_hit[i] = pin_s2[i] ^ pin_s3[i];
        default: edge_hit[i] = 1'b0;
      endcase
      own_ovf[i] = tb_ovf[ch_cfg[i].tb_sel];
      // Capture waits for an edge, compare waits for a timebase step
      if (is_cap(ch_cfg[i].mode)) begin
        raw_evt[i] = edge_hit[i];
      end else begin
        raw_evt[i] = is_cmp(ch_cfg[i].mode) & tb_stepped[ch_cfg[i].tb_sel];
      end
      // Staggered: each channel is served once in eight cycles
      slot_ok[i] = ~staggered | (slot == `CCAU_SLOTW'(i));
      if (staggered) begin
        hit[i] = slot_ok[i] & (pend[i] | raw_evt[i]);
        next_pend[i] = ~slot_ok[i] & (pend[i] | raw_evt[i]);
      end else begin
        hit[i] = raw_evt[i];
        next_pend[i] = 1'b0;
      end
      // Staggered compare sees the value at its slot; a fast timer may skip it
      match[i] = hit[i] & is_cmp(ch_cfg[i].mode)
               & (tb_value[ch_cfg[i].tb_sel] == cc_value[i])
               & ~spent[i]
               & ~(is_once(ch_cfg[i].mode) & fired[i]);
    end
  end

  // Pair lead: lower channel whose pin also serves channel i + 8
  function automatic logic pair_lead(input int i, input ccau_ch_cfg_t c);
    return (i < `CCAU_HALF) && c.double_reg;
  endfunction

  // Channel registers and their interrupt requests
  always_comb begin
    for (int i = 0; i < `CCAU_NCH; i++) begin
      next_cc_value[i] = cc_value[i];
      next_cc_irq[i] = 1'b0;
      // Capture beats a software write in the same cycle
      if (hit[i] && is_cap(ch_cfg[i].mode)) begin
        next_cc_value[i] = tb_value[ch_cfg[i].tb_sel];
        next_cc_irq[i] = 1'b1;
      end else if (cc_wr[i]) begin
        next_cc_value[i] = cc_wdata;
      end
      if (match[i]) begin
        next_cc_irq[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cc_irq <= '0;
      for (int i = 0; i < `CCAU_NCH; i++) begin
        cc_value[i] <= `CCAU_VAL_RST;
      end
    end else begin
      cc_irq <= next_cc_irq;
      cc_value <= next_cc_value;
    end
  end

  // Match locks; a set wins over a same-cycle clear
  always_comb begin
    for (int i = 0; i < `CCAU_NCH; i++) begin
      next_fired[i] = fired[i];
      next_spent[i] = spent[i];
      // Once-per-period lock releases on overflow
      if (own_ovf[i]) begin
        next_fired[i] = 1'b0;
      end
      if (match[i]) begin
        next_fired[i] = 1'b1;
      end
      // Single event rearms on a new compare value or option off
      if (cc_wr[i] || !ch_cfg[i].single_event) begin
        next_spent[i] = 1'b0;
      end
      if (match[i] && ch_cfg[i].single_event) begin
        next_spent[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fired <= '0;
      spent <= '0;
    end else begin
      fired <= next_fired;
      spent <= next_spent;
    end
  end

  // Pin levels and enables
  always_comb begin
    for (int i = 0; i < `CCAU_NCH; i++) begin
      toggle[i] = match[i] & (ch_cfg[i].mode == ccau_cmp1);
      if (pair_lead(i, ch_cfg[i])) begin
        toggle[i] = match[i] | match[(i + `CCAU_HALF) % `CCAU_NCH];
      end
    end
    for (int i = 0; i < `CCAU_NCH; i++) begin
      next_ch_pin_out[i] = ch_pin_out[i];
      next_ch_pin_oe_n[i] = ~drives_pin(ch_cfg[i].mode);
      if (pair_lead(i, ch_cfg[i])) begin
        next_ch_pin_oe_n[i] = 1'b0;
      end
      if (toggle[i]) begin
        next_ch_pin_out[i] = ~ch_pin_out[i];
      end else if (ch_cfg[i].mode == ccau_cmp3) begin
        if (match[i]) begin
          next_ch_pin_out[i] = 1'b1;
        end else if (own_ovf[i]) begin
          next_ch_pin_out[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch_pin_out <= '0;
      ch_pin_oe_n <= '1;
    end else begin
      ch_pin_out <= next_ch_pin_out;
      ch_pin_oe_n <= next_ch_pin_oe_n;
    end
  end

  // Staggered service state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot <= `CCAU_SLOT_RST;
      pend <= '0;
    end else begin
      slot <= next_slot;
      pend <= next_pend;
    end
  end
endmodule // ccau_top

//--- bench/ccau_top_asserts.sv
// Purpose: Port checker for the capture/compare array
// Assumes: Bench holds configuration steady while it runs
// Notes: Watches timebase 0 and channels 0, 1, 3, 5 only
`timescale 1ns/1ps
`include "ccau_params.svh"
module ccau_chk
  import ccau_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic staggered,
  input ccau_tb_cfg_t [1:0] tb_cfg,
  input wire logic [1:0] tb_load,
  input ccau_ch_cfg_t [15:0] ch_cfg,
  input wire logic [15:0] ch_pin_in,
  input wire logic [1:0][15:0] tb_value,
  input wire logic [1:0] tb_ovf,
  input wire logic [15:0][15:0] cc_value,
  input wire logic [15:0] cc_irq,
  input wire logic [15:0] ch_pin_out,
  input wire logic [15:0] ch_pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ovf_reload: assert property (tb_ovf[0] |-> tb_value[0] == tb_cfg[0].reload)
    else $error("reload value wrong");
  a_ovf_wrap: assert property (tb_ovf[0] |-> $past(tb_value[0]) == `CCAU_TB_MAX)
    else $error("overflow not from top");
  a_cap_rise: assert property (ch_cfg[0].mode == ccau_cap_rise && !staggered
    && $rose(ch_pin_in[0]) |-> ##3 cc_irq[0]) else $error("capture missed");
  a_cap_skip: assert property (ch_cfg[0].mode == ccau_cap_fall && $rose(ch_pin_in[0])
    |-> ##3 !cc_irq[0] [*8]) else $error("wrong edge captured");
  a_cmp_hit: assert property (ch_cfg[1].mode == ccau_cmp0 && !staggered && !$past(tb_load[0])
    && !ch_cfg[1].tb_sel && $changed(tb_value[0]) && tb_value[0] == cc_value[1]
    |-> ##1 cc_irq[1])
    else $error("compare missed");
  a_tog_irq: assert property (ch_cfg[3].mode == ccau_cmp1 && $changed(ch_pin_out[3])
    |-> cc_irq[3]) else $error("toggle without match");
  a_set_irq: assert property (ch_cfg[5].mode == ccau_cmp3 && $rose(ch_pin_out[5])
    |-> cc_irq[5]) else $error("set without match");
  a_oe_drive: assert property (ch_cfg[3].mode == ccau_cmp1 |=> !ch_pin_oe_n[3])
    else $error("compare pin not driven");
endmodule // ccau_chk

//--- bench/ccau_pin_model.sv
// Purpose: Far-side pins of the capture/compare array
// Assumes: Tasks are called from the falling edge
// Notes: Pin level resolved from the design's enables
`timescale 1ns/1ps
module ccau_pin_model
(
  input wire logic clk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  output logic [15:0] pin_in,
  output logic count_pin
);
  logic [15:0] lvl = 16'h0000;
  initial count_pin = 1'b0;
  // Driven pins read back the design's own level
  assign pin_in = (pin_oe_n & lvl) | (~pin_oe_n & pin_out);
  // Long holds so the three-stage synchroniser sees every level
  task automatic drive(input int ch, input logic v, input int n);
    lvl[ch] = v;
    repeat (n) @(negedge clk);
  endtask
  task automatic count(input int n);
    repeat (n) begin
      count_pin = 1'b1;
      repeat (6) @(negedge clk);
      count_pin = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask
endmodule // ccau_pin_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the capture/compare array
// Assumes: Inputs change on the falling clock edge
// Notes: Timebase 1 stands still so captures are exact
`timescale 1ns/1ps
module tb
  import ccau_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic staggered = 1'b0;
  logic nb_tick = 1'b0;
  logic counting = 1'b0;
  logic ext_count_pin;
  ccau_tb_cfg_t [1:0] tb_cfg = '0;
  ccau_ch_cfg_t [15:0] ch_cfg = '0;
  logic [1:0] tb_load = '0;
  logic [1:0][15:0] tb_load_value = '0;
  logic [15:0] cc_wr = '0;
  logic [15:0] cc_wdata = '0;
  logic [15:0] ch_pin_in, ch_pin_out, ch_pin_oe_n, cc_irq, pin_q, a;
  logic [1:0][15:0] tb_value;
  logic [1:0] tb_ovf;
  logic [15:0][15:0] cc_value;
  logic [31:0] seed = 32'hc662_4ba3;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int irqs [16];
  int tog [16];
  ccau_top dut (.clk, .reset, .staggered, .tb_cfg, .tb_load, .tb_load_value, .nb_tick,
    .ext_count_pin, .ch_cfg, .cc_wr, .cc_wdata, .ch_pin_in, .tb_value, .tb_ovf,
    .cc_value, .cc_irq, .ch_pin_out, .ch_pin_oe_n);
  ccau_pin_model pins (.clk, .pin_out(ch_pin_out), .pin_oe_n(ch_pin_oe_n),
    .pin_in(ch_pin_in), .count_pin(ext_count_pin));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
    for (int i = 0; i < 16; i++) begin
      if (counting && cc_irq[i] === 1'b1) irqs[i]++;
      if (counting && ch_pin_out[i] !== pin_q[i]) tog[i]++;
    end
    pin_q = ch_pin_out;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int hits(input ccau_ch_cfg_t c, input int per, input int extra);
    if (c.single_event) return 1;
    if (c.mode == ccau_cap_both) return 2 * per;
    if (c.mode inside {ccau_cmp2, ccau_cmp3}) return per;
    return per + extra;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Trailing idle cycle keeps strobes from being re-raised in one step
  task automatic wr(input logic [15:0] m, input logic [15:0] d);
    cc_wr = m;
    cc_wdata = d;
    tick(1);
    cc_wr = '0;
    tick(1);
  endtask
  task automatic load(input int t, input logic [15:0] v);
    tb_load[t] = 1'b1;
    tb_load_value[t] = v;
    tick(1);
    tb_load[t] = 1'b0;
    tick(1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    tick(10);
    reset = 1'b0;
    check("oe_n", 16'hffff, ch_pin_oe_n);
    tb_cfg[1] = '{1'b1, ccau_src_neighbour, 3'h0, 16'h0000};
    repeat (5) begin
      nb_tick = 1'b1;
      tick(1);
      nb_tick = 1'b0;
      tick(2);
    end
    check("neighbour", 16'h0005, tb_value[1]);
    tb_cfg[0] = '{1'b1, ccau_src_external, 3'h0, 16'hff00};
    pins.count(3);
    check("external", 16'h0003, tb_value[0]);
    seed = lfsr(seed);
    tb_cfg[1].run = 1'b0;
    load(1, seed[15:0]);
    ch_cfg[0].tb_sel = 1'b1;
    for (int m = 1; m < 4; m++) begin
      staggered = m[1];
      ch_cfg[0].mode = ccau_mode_t'(m);
      irqs[0] = 0;
      counting = 1'b1;
      pins.drive(0, 1'b1, 20);
      pins.drive(0, 1'b0, 20);
      counting = 1'b0;
      check("cap irqs", 16'(hits(ch_cfg[0], 1, 0)), 16'(irqs[0]));
      check("cap value", seed[15:0], cc_value[0]);
    end
    staggered = 1'b0;
    ch_cfg[0].mode = ccau_mode_off;
    tb_cfg[0].src = ccau_src_presc;
    ch_cfg[1].mode = ccau_cmp0;
    ch_cfg[2].mode = ccau_cmp2;
    ch_cfg[3].mode = ccau_cmp1;
    ch_cfg[4].mode = ccau_cmp1;
    ch_cfg[4].double_reg = 1'b1;
    ch_cfg[5].mode = ccau_cmp3;
    ch_cfg[6].mode = ccau_cmp0;
    ch_cfg[6].single_event = 1'b1;
    ch_cfg[12].mode = ccau_cmp0;
    seed = lfsr(seed);
    a = {10'h3fc, seed[5:0]} | 16'h0008;
    wr(16'h007e, a);
    wr(16'h1000, a + 16'h0030);
    irqs = '{default: 0};
    tog = '{default: 0};
    counting = 1'b1;
    load(0, 16'hff00);
    // Second match inside the first period only counts where allowed
    tick(80);
    wr(16'h0006, a + 16'h0060);
    repeat (2) @(posedge tb_ovf[0]);
    tick(3);
    counting = 1'b0;
    for (int i = 1; i < 7; i++) begin
      check("cmp irqs", 16'(hits(ch_cfg[i], 2, int'(i < 3))), 16'(irqs[i]));
    end
    check("toggle pin", 16'(hits(ch_cfg[3], 2, 0)), 16'(tog[3]));
    check("double pin", 16'(hits(ch_cfg[4], 2, 0) + hits(ch_cfg[12], 2, 0)), 16'(tog[4]));
    check("set pin", 16'(2 * hits(ch_cfg[5], 2, 0)), 16'(tog[5]));
    check("drive", 16'h0000, ch_pin_oe_n & 16'h0028);
    final_report();
  end
endmodule // tb
bind ccau_top ccau_chk chk (.clk, .reset, .staggered, .tb_cfg, .tb_load, .ch_cfg, .ch_pin_in,
  .tb_value, .tb_ovf, .cc_value, .cc_irq, .ch_pin_out, .ch_pin_oe_n);
